/* File: prpe_defines.vh */
`ifndef PRPE_DEFINES_VH
`define PRPE_DEFINES_VH
// Register byte offsets on the APB bus.
`define PRPE_OFF_CTRL 12'h000
`define PRPE_OFF_MODE 12'h004
`define PRPE_OFF_TIMING 12'h008
`define PRPE_OFF_RXADDR_LO 12'h00C
`define PRPE_OFF_RXADDR_HI 12'h010
`define PRPE_OFF_TXADDR_LO 12'h014
`define PRPE_OFF_TXADDR_HI 12'h018
`define PRPE_OFF_RAM 12'h01C
`define PRPE_OFF_STATUS 12'h020
// Control register fields.
`define PRPE_CTRL_DIR 0
`define PRPE_CTRL_ACK_MODE 1
`define PRPE_CTRL_RATE 2
`define PRPE_CTRL_AW_LO 3
`define PRPE_CTRL_AW_HI 4
`define PRPE_CTRL_WHITEN 5
`define PRPE_CTRL_CRC_EN 6
`define PRPE_CTRL_VARIANT 7
`define PRPE_CTRL_CRC16 8
`define PRPE_CTRL_REPLY 9
`define PRPE_CTRL_DYNLEN 10
`define PRPE_CTRL_ACKPL 11
`define PRPE_CTRL_PROTO_LO 12
`define PRPE_CTRL_PROTO_HI 13
`define PRPE_CTRL_TXLEN_LO 16
`define PRPE_CTRL_TXLEN_HI 23
`define PRPE_CTRL_RXLEN_LO 24
`define PRPE_CTRL_RXLEN_HI 31
// Mode register fields.
`define PRPE_MODE_PLAIN_REPLY 0
`define PRPE_MODE_LOW_RATE 1
`define PRPE_MODE_PREAMBLE_EXT 2
// Timing register fields.
`define PRPE_TIM_WAIT_LO 0
`define PRPE_TIM_WAIT_HI 15
`define PRPE_TIM_TURN_LO 16
`define PRPE_TIM_TURN_HI 30
`define PRPE_TIM_TO_DIS 31
// RAM control register fields.
`define PRPE_RAM_TXRDY 0
`define PRPE_RAM_RXRDY 1
`define PRPE_RAM_TXSA_LO 2
`define PRPE_RAM_TXSA_HI 15
`define PRPE_RAM_RXSA_LO 16
`define PRPE_RAM_RXSA_HI 29
// Status bits, written one to clear.
`define PRPE_ST_TXDONE 0
`define PRPE_ST_RXDONE 1
`define PRPE_ST_ACKDONE 2
`define PRPE_ST_TIMEOUT 3
// Fixed values.
`define PRPE_SRAM_BASE 32'h50028000
`define PRPE_PROTO_FIRST 2'h2
`define PRPE_PROTO_SECOND 2'h3
`define PRPE_CLK_MHZ 40
`define PRPE_CTRL_RESET 32'h00000000
`endif

/* File: prpe_ctr.v */
`timescale 1ns/10ps
// Microsecond-scaled down counter: loads a count, ticks at one microsecond, flags expiry.
module prpe_ctr #(
    parameter WIDTH = 16,
    parameter CLK_MHZ = 40
) (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [WIDTH-1:0] load_val,
    input wire run,
    output reg expired
);
    localparam [7:0] PRE_MAX = CLK_MHZ - 1;
    reg [7:0] pre_reg;
    reg [WIDTH-1:0] cnt_reg;

    // Prescaler gives a microsecond tick; main count steps on each tick.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 8'h00;
            cnt_reg <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end else if (load) begin
            pre_reg <= 8'h00;
            cnt_reg <= load_val;
            expired <= 1'b0;
        end else if (run && !expired) begin
            if (pre_reg == PRE_MAX) begin
                pre_reg <= 8'h00;
                if (cnt_reg == {WIDTH{1'b0}}) begin
                    expired <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end else begin
                pre_reg <= pre_reg + 8'h01;
            end
        end
    end
endmodule // prpe_ctr

/* File: prpe_engine.v */
`timescale 1ns/10ps
// Notes on behaviour
// (RQ1) Packet SRAM address is fixed base plus transmit or receive start offset.
// (RQ2) Framing selector: 2 is first compatible protocol, 3 the second.
// (RQ3) Enhanced control 0 gives normal operation, 1 gives acknowledged operation.
// (RQ4) Rate select 0 means 1 Mbps, 1 means 2 Mbps.
// (RQ5) Address width codes 0..3 give 2, 3, 4, 5 byte addresses.
// (RQ6) High address byte used only for the 5-byte width.
// (RQ7) Whitening 0 off, 1 on; receiver must match transmitter.
// (RQ8) With checksum enabled, size 0 is 8-bit, 1 is 16-bit.
// (RQ9) Direction 0 is transmitter role, 1 is receiver role.
// (RQ10) Transmit starts once transmit-ready is set after configuration.
// (RQ11) Reception starts once receive-ready is set after receiver role chosen.
// (RQ12) Timeout disable bit low enables microsecond receive timeout.
// (RQ13) Normal mode receiver length must equal transmitter length.
// (RQ14) Second protocol: leave whitening unprogrammed in receiver and enhanced set-up.
// (RQ15) Bit 7 selects enhanced variant under second protocol only.
// (RQ16) Enhanced transmitter waits for acknowledge only when reply enable is 1.
// (RQ17) Acknowledge wait needs dynamic length, receive-ready, address, turnaround, timeout set.
// (RQ18) Turnaround equals programmed wait plus phy start-up and shut-down time.
// (RQ19) Enhanced receiver with acknowledge payload sends the transmit-area packet.
// (RQ20) Transmitter uses receive address as peer; receiver uses target address.
// (RQ21) Plain reply bit makes transmitter also receive a reply packet.
// (RQ22) Low-rate bit selects 250k with second protocol, normal mode, 1 Mbps.
// (RQ23) Low-rate use requires preamble extension set by software.
// (RQ24) Software drops ready bits after clearing completion status.
// (RQ25) Completion of transmit, receive, acknowledge or timeout raises a status event.
`include "prpe_defines.vh"
module prpe_engine #(
    parameter [14:0] PHY_SWITCH_US = 15'h0028,
    parameter LEN_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] sram_addr,
    output reg sram_req,
    output reg sram_write,
    input wire sram_ack,
    output reg radio_tx_on,
    output reg radio_rx_on,
    output reg [39:0] radio_peer_addr,
    output reg [2:0] radio_addr_bytes,
    output reg [1:0] radio_rate,
    output reg radio_whiten,
    output reg [1:0] radio_crc_bytes,
    output reg [1:0] radio_variant,
    output reg radio_preamble_ext,
    output reg [LEN_W-1:0] radio_len,
    input wire radio_pkt_done,
    input wire radio_sync
);
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_TX = 7'h02;
    localparam [6:0] S_TURN = 7'h04;
    localparam [6:0] S_RX = 7'h08;
    localparam [6:0] S_TXREPLY = 7'h10;
    localparam [6:0] S_DONE = 7'h20;
    localparam [6:0] S_HOLD = 7'h40;

    reg [31:0] ctrl_reg;
    reg [31:0] mode_reg;
    reg [31:0] timing_reg;
    reg [31:0] rxa_lo_reg;
    reg [31:0] rxa_hi_reg;
    reg [31:0] txa_lo_reg;
    reg [31:0] txa_hi_reg;
    reg [31:0] ram_reg;
    reg [3:0] status_reg;
    reg [3:0] status_next;
    reg [6:0] state_reg;
    reg [6:0] state_next;
    reg [3:0] evt;
    reg sync1_reg, sync2_reg, done1_reg, done2_reg, done3_reg;
    reg ctr_load;
    reg [15:0] ctr_val;
    reg ctr_run;
    wire ctr_exp;
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && !penable && !pwrite;
    wire pkt_done = done2_reg && !done3_reg;
    wire is_rx_role = ctrl_reg[`PRPE_CTRL_DIR]; // see RQ9
    wire enhanced = ctrl_reg[`PRPE_CTRL_ACK_MODE]; // see RQ3
    wire second_proto = ctrl_reg[`PRPE_CTRL_PROTO_HI:`PRPE_CTRL_PROTO_LO] == `PRPE_PROTO_SECOND; // see RQ2
    wire first_proto = ctrl_reg[`PRPE_CTRL_PROTO_HI:`PRPE_CTRL_PROTO_LO] == `PRPE_PROTO_FIRST; // see RQ2
    wire plain_reply_mode = mode_reg[`PRPE_MODE_PLAIN_REPLY];
    wire low_rate_enable = mode_reg[`PRPE_MODE_LOW_RATE];
    wire tx_ready = ram_reg[`PRPE_RAM_TXRDY];
    wire rx_ready = ram_reg[`PRPE_RAM_RXRDY];
    // Transmitter expects an answer in enhanced mode with reply enable, or in normal mode with the plain reply bit set.
    wire want_reply = (enhanced && ctrl_reg[`PRPE_CTRL_REPLY]) || (!enhanced && plain_reply_mode); // see RQ16 RQ21
    // Receiver answers in enhanced or plain reply mode.
    wire send_answer = enhanced || plain_reply_mode; // see RQ19 RQ21
    wire [15:0] turn_us = {1'b0, timing_reg[`PRPE_TIM_TURN_HI:`PRPE_TIM_TURN_LO]} + {1'b0, PHY_SWITCH_US}; // see RQ18

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Radio synchronisers and edge detection of packet completion.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            done1_reg <= 1'b0;
            done2_reg <= 1'b0;
            done3_reg <= 1'b0;
        end else begin
            sync1_reg <= radio_sync;
            sync2_reg <= sync1_reg;
            done1_reg <= radio_pkt_done;
            done2_reg <= done1_reg;
            done3_reg <= done2_reg;
        end
    end

    // Register writes from APB; data takes effect at the access edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `PRPE_CTRL_RESET;
            mode_reg <= 32'h00000000;
            timing_reg <= 32'h00000000;
            rxa_lo_reg <= 32'h00000000;
            rxa_hi_reg <= 32'h00000000;
            txa_lo_reg <= 32'h00000000;
            txa_hi_reg <= 32'h00000000;
            ram_reg <= 32'h00000000;
        end else if (wr_en) begin
            case (paddr)
                `PRPE_OFF_CTRL: ctrl_reg <= pwdata;
                `PRPE_OFF_MODE: mode_reg <= {29'h00000000, pwdata[2:0]};
                `PRPE_OFF_TIMING: timing_reg <= pwdata;
                `PRPE_OFF_RXADDR_LO: rxa_lo_reg <= pwdata;
                `PRPE_OFF_RXADDR_HI: rxa_hi_reg <= {24'h000000, pwdata[7:0]};
                `PRPE_OFF_TXADDR_LO: txa_lo_reg <= pwdata;
                `PRPE_OFF_TXADDR_HI: txa_hi_reg <= {24'h000000, pwdata[7:0]};
                `PRPE_OFF_RAM: ram_reg <= {2'h0, pwdata[29:0]};
                default: ;
            endcase
        end
    end

    // Status bits: hardware set beats a same-cycle write-one clear.
    always @* begin
        status_next = status_reg;
        if (wr_en && paddr == `PRPE_OFF_STATUS) begin
            status_next = status_reg & ~pwdata[3:0]; // see RQ24
        end
        status_next = status_next | evt; // see RQ25
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 4'h0;
        end else begin
            status_reg <= status_next;
        end
    end

    // Read data is registered during the setup phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `PRPE_OFF_CTRL: prdata <= ctrl_reg;
                `PRPE_OFF_MODE: prdata <= mode_reg;
                `PRPE_OFF_TIMING: prdata <= timing_reg;
                `PRPE_OFF_RXADDR_LO: prdata <= rxa_lo_reg;
                `PRPE_OFF_RXADDR_HI: prdata <= rxa_hi_reg;
                `PRPE_OFF_TXADDR_LO: prdata <= txa_lo_reg;
                `PRPE_OFF_TXADDR_HI: prdata <= txa_hi_reg;
                `PRPE_OFF_RAM: prdata <= ram_reg;
                `PRPE_OFF_STATUS: prdata <= {21'h000000, state_reg, status_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Packet sequencer: transmit, turnaround, listen, answer.
    always @* begin
        state_next = state_reg;
        evt = 4'h0;
        ctr_load = 1'b0;
        ctr_val = 16'h0000;
        ctr_run = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (!is_rx_role && tx_ready) begin
                    state_next = S_TX; // see RQ10
                end else if (is_rx_role && rx_ready) begin
                    state_next = S_RX; // see RQ11
                    ctr_load = 1'b1;
                    ctr_val = timing_reg[`PRPE_TIM_WAIT_HI:`PRPE_TIM_WAIT_LO]; // see RQ12
                end
            end
            S_TX: begin
                if (pkt_done) begin
                    evt[`PRPE_ST_TXDONE] = 1'b1;
                    if (want_reply && rx_ready) begin
                        state_next = S_TURN;
                        ctr_load = 1'b1;
                        ctr_val = turn_us - 16'h0001; // Counter expires one tick after zero; see RQ18
                    end else begin
                        state_next = S_DONE; // see RQ16
                    end
                end
            end
            S_TURN: begin
                ctr_run = 1'b1;
                if (ctr_exp) begin
                    state_next = S_RX;
                    ctr_load = 1'b1;
                    ctr_val = timing_reg[`PRPE_TIM_WAIT_HI:`PRPE_TIM_WAIT_LO];
                end
            end
            S_RX: begin
                ctr_run = !timing_reg[`PRPE_TIM_TO_DIS]; // see RQ12
                if (pkt_done) begin
                    if (!is_rx_role) begin
                        evt[`PRPE_ST_ACKDONE] = 1'b1;
                        state_next = S_DONE;
                    end else begin
                        evt[`PRPE_ST_RXDONE] = 1'b1;
                        if (send_answer) begin
                            state_next = S_TXREPLY; // see RQ19
                        end else begin
                            state_next = S_DONE;
                        end
                    end
                end else if (ctr_exp && !timing_reg[`PRPE_TIM_TO_DIS]) begin
                    evt[`PRPE_ST_TIMEOUT] = 1'b1; // see RQ12
                    state_next = S_DONE;
                end
            end
            S_TXREPLY: begin
                if (pkt_done) begin
                    evt[`PRPE_ST_ACKDONE] = 1'b1;
                    state_next = S_DONE;
                end
            end
            S_DONE: state_next = S_HOLD;
            S_HOLD: begin
                // Wait for software to drop ready bits before rearming.
                if (!tx_ready && !rx_ready) begin
                    state_next = S_IDLE; // see RQ24
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Radio control outputs derived from state and configuration.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            radio_tx_on <= 1'b0;
            radio_rx_on <= 1'b0;
            radio_peer_addr <= 40'h0000000000;
            radio_addr_bytes <= 3'h2;
            radio_rate <= 2'h0;
            radio_whiten <= 1'b0;
            radio_crc_bytes <= 2'h0;
            radio_variant <= 2'h0;
            radio_preamble_ext <= 1'b0;
            radio_len <= {LEN_W{1'b0}};
            sram_addr <= 32'h00000000;
            sram_req <= 1'b0;
            sram_write <= 1'b0;
        end else begin
            radio_tx_on <= state_next == S_TX || state_next == S_TXREPLY;
            radio_rx_on <= state_next == S_RX && sync2_reg;
            radio_addr_bytes <= {1'b0, ctrl_reg[`PRPE_CTRL_AW_HI:`PRPE_CTRL_AW_LO]} + 3'h2; // see RQ5
            // Peer address from receive regs in transmitter role, target regs in receiver role.
            if (!is_rx_role) begin
                radio_peer_addr <= {(ctrl_reg[`PRPE_CTRL_AW_HI:`PRPE_CTRL_AW_LO] == 2'h3) ? rxa_hi_reg[7:0] : 8'h00,
                                    rxa_lo_reg}; // see RQ6 RQ20
            end else begin
                radio_peer_addr <= {(ctrl_reg[`PRPE_CTRL_AW_HI:`PRPE_CTRL_AW_LO] == 2'h3) ? txa_hi_reg[7:0] : 8'h00,
                                    txa_lo_reg}; // see RQ6 RQ20
            end
            // Low rate forces the 250k code; otherwise 1 or 2 Mbps.
            radio_rate <= low_rate_enable ? 2'h2 : {1'b0, ctrl_reg[`PRPE_CTRL_RATE]}; // see RQ4 RQ22
            radio_preamble_ext <= mode_reg[`PRPE_MODE_PREAMBLE_EXT]; // see RQ23
            radio_whiten <= ctrl_reg[`PRPE_CTRL_WHITEN]; // see RQ7
            radio_crc_bytes <= !ctrl_reg[`PRPE_CTRL_CRC_EN] ? 2'h0 :
                               (ctrl_reg[`PRPE_CTRL_CRC16] ? 2'h2 : 2'h1); // see RQ8
            // Variant code: 0 none, 1 variant zero, 2 variant one; first protocol ignores bit 7.
            radio_variant <= (enhanced && second_proto) ? (ctrl_reg[`PRPE_CTRL_VARIANT] ? 2'h2 : 2'h1) :
                             2'h0; // see RQ15
            radio_len <= (state_next == S_RX) ? ctrl_reg[`PRPE_CTRL_RXLEN_HI:`PRPE_CTRL_RXLEN_LO] :
                         ctrl_reg[`PRPE_CTRL_TXLEN_HI:`PRPE_CTRL_TXLEN_LO];
            sram_req <= (state_next == S_TX || state_next == S_TXREPLY || state_next == S_RX) && !sram_ack;
            sram_write <= state_next == S_RX;
            if (state_next == S_RX) begin
                sram_addr <= `PRPE_SRAM_BASE + {18'h00000, ram_reg[`PRPE_RAM_RXSA_HI:`PRPE_RAM_RXSA_LO]}; // see RQ1
            end else begin
                sram_addr <= `PRPE_SRAM_BASE + {18'h00000, ram_reg[`PRPE_RAM_TXSA_HI:`PRPE_RAM_TXSA_LO]}; // see RQ1
            end
        end
    end

    // Microsecond counter shared by turnaround and receive timeout.
    prpe_ctr #(
        .WIDTH(16),
        .CLK_MHZ(`PRPE_CLK_MHZ)
    ) u_ctr (
        .pclk(pclk),
        .presetn(presetn),
        .load(ctr_load),
        .load_val(ctr_val),
        .run(ctr_run),
        .expired(ctr_exp)
    );
endmodule // prpe_engine

/* File: prpe_chk_assertions.sv */
`timescale 1ns/10ps
`include "prpe_defines.vh"
// Shadows the words written over the bus and checks the radio settings and memory addresses against them.
module prpe_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] sram_addr,
    input wire sram_req,
    input wire sram_write,
    input wire radio_tx_on,
    input wire radio_rx_on,
    input wire [2:0] radio_addr_bytes,
    input wire [1:0] radio_rate,
    input wire radio_whiten,
    input wire [1:0] radio_crc_bytes,
    input wire [1:0] radio_variant
);
    reg [31:0] ctrl_reg;
    reg [2:0] mode_reg;
    reg [29:0] ram_reg;
    wire wr = psel && penable && pwrite;
    wire act = radio_tx_on || radio_rx_on;
    // Copies land at the access edge, as the engine's own registers do.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 32'h00000000;
            mode_reg <= 3'h0;
            ram_reg <= 30'h00000000;
        end else if (wr) begin
            if (paddr == `PRPE_OFF_CTRL) ctrl_reg <= pwdata;
            if (paddr == `PRPE_OFF_MODE) mode_reg <= pwdata[2:0];
            if (paddr == `PRPE_OFF_RAM) ram_reg <= pwdata[29:0];
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // While the radio is active its settings follow the shadowed fields.
    a_aw_map: assert property (act |-> radio_addr_bytes == {1'b0, ctrl_reg[4:3]} + 3'h2)
        else $error("address width mismatch");
    a_rate_map: assert property (act |-> radio_rate == (mode_reg[1] ? 2'h2 : {1'b0, ctrl_reg[2]}))
        else $error("air rate mismatch");
    a_whiten_map: assert property (act |-> radio_whiten == ctrl_reg[5])
        else $error("whitening mismatch");
    a_crc_size: assert property (act |-> radio_crc_bytes == (ctrl_reg[6] ? (ctrl_reg[8] ? 2'h2 : 2'h1) : 2'h0))
        else $error("checksum size mismatch");
    a_variant_sel: assert property (act && ctrl_reg[1] |->
        radio_variant == (ctrl_reg[13:12] == 2'h3 ? {ctrl_reg[7], !ctrl_reg[7]} : 2'h0))
        else $error("enhanced variant mismatch");
    // Packet memory is reached at the fixed base plus the start field of the direction in use.
    a_tx_fetch: assert property (sram_req && !sram_write |-> sram_addr == `PRPE_SRAM_BASE + ram_reg[15:2])
        else $error("fetch address mismatch");
    a_rx_store: assert property (sram_req && sram_write |-> sram_addr == `PRPE_SRAM_BASE + ram_reg[29:16])
        else $error("store address mismatch");
    // A ready bit starts the role chosen by the direction bit within a few cycles.
    a_tx_start: assert property (wr && paddr == `PRPE_OFF_RAM && pwdata[0] && !ctrl_reg[0] |->
        ##[1:3] (sram_req || radio_tx_on))
        else $error("transmit did not start");
    a_rx_start: assert property (wr && paddr == `PRPE_OFF_RAM && pwdata[1] && ctrl_reg[0] |->
        ##[1:6] (radio_rx_on && !radio_tx_on))
        else $error("listening did not start");
    a_apb_answer: assert property (psel && penable |-> pready && !pslverr)
        else $error("bus answer not immediate");
    c_tx_on: cover property ($rose(radio_tx_on));
    c_rx_store: cover property (sram_req && sram_write);
    c_reply: cover property (radio_tx_on ##[1:300] radio_rx_on);
endmodule // prpe_chk

/* File: prpe_peer.sv */
`timescale 1ns/10ps
// Far-side radio and packet memory: acknowledges memory requests and finishes packets on air.
module prpe_peer (
    input wire pclk,
    input wire presetn,
    input wire sram_req,
    input wire radio_tx_on,
    input wire radio_rx_on,
    input wire answer,
    input wire slow,
    output reg sram_ack,
    output reg radio_pkt_done,
    output reg radio_sync
);
    reg [2:0] wait_cnt;
    reg [5:0] air_cnt;
    wire busy = radio_tx_on || (radio_rx_on && answer);
    // Memory answers at once, or after four cycles when slow is set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sram_ack <= 1'b0;
            wait_cnt <= 3'h0;
        end else begin
            sram_ack <= sram_req && !sram_ack && wait_cnt >= (slow ? 3'h4 : 3'h0);
            wait_cnt <= (sram_req && !sram_ack) ? wait_cnt + 3'h1 : 3'h0;
        end
    end
    // A packet takes twenty cycles on air; a listener only hears one when the peer answers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            air_cnt <= 6'h00;
            radio_pkt_done <= 1'b0;
            radio_sync <= 1'b0;
        end else begin
            air_cnt <= busy ? (air_cnt == 6'h3F ? air_cnt : air_cnt + 6'h01) : 6'h00;
            radio_pkt_done <= busy && air_cnt >= 6'h14;
            radio_sync <= 1'b1;
        end
    end
endmodule // prpe_peer

/* File: tb.sv */
`timescale 1ns/10ps
`include "prpe_defines.vh"
// Drives the engine over the register bus and plays the far radio through the peer model.
module tb;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [2:0] mode;
        logic [2:0] aw;
        logic [1:0] rate;
        logic wh;
        logic [1:0] crc;
        logic [1:0] vr;
    } prpe_row_t;
    reg pclk, presetn, psel, penable, pwrite, answer, slow;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd, wr_seen;
    wire [31:0] prdata, sram_addr;
    wire pready, pslverr, sram_req, sram_write, sram_ack, radio_tx_on, radio_rx_on;
    wire radio_whiten, radio_preamble_ext, radio_pkt_done, radio_sync;
    wire [39:0] radio_peer_addr;
    wire [2:0] radio_addr_bytes;
    wire [1:0] radio_rate, radio_crc_bytes, radio_variant;
    wire [7:0] radio_len;
    integer errors, cmp_count, i, n;
    integer cyc = 0;
    prpe_row_t rows [0:5];
    prpe_engine #(.PHY_SWITCH_US(15'h0003), .LEN_W(8)) prpe_engine_i (.*);
    prpe_peer prpe_peer_i (.*);
    // Compares one value and counts it.
    task chk(input [39:0] s, input [39:0] e);
        cmp_count = cmp_count + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One bus transfer: setup, then access held until ready; read data taken at that edge.
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reads status until one of the masked bits shows, a bounded number of times.
    task poll(input [31:0] m);
        integer k;
        rd = 32'h00000000;
        for (k = 0; k < 100 && (rd & m) == 0; k = k + 1) apb(1'b0, `PRPE_OFF_STATUS, 32'h00000000);
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Clock at 40 MHz.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Hang ceiling, and capture of the last store address; a transmit clears the capture.
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (sram_req && sram_write) wr_seen <= sram_addr;
        else if (radio_tx_on) wr_seen <= 32'h0;
        if (cyc == 20000) begin
            errors = errors + 1;
            close_out;
        end
    end
    // Reset, a table of transmit set-ups, then receive, timeout and reply cases.
    initial begin
        {presetn, psel, penable, pwrite, answer, slow, paddr, pwdata} = 0;
        {errors, cmp_count} = 0;
        rows[0] = '{32'h00102000, 3'h0, 3'h2, 2'h0, 1'b0, 2'h0, 2'h0};
        rows[1] = '{32'h0020306C, 3'h0, 3'h3, 2'h1, 1'b1, 2'h1, 2'h0};
        rows[2] = '{32'h000831D2, 3'h0, 3'h4, 2'h0, 1'b0, 2'h2, 2'h2};
        rows[3] = '{32'h0004209A, 3'h0, 3'h5, 2'h0, 1'b0, 2'h0, 2'h0};
        rows[4] = '{32'h0001301A, 3'h0, 3'h5, 2'h0, 1'b0, 2'h0, 2'h1};
        rows[5] = '{32'h00203000, 3'h6, 3'h2, 2'h2, 1'b0, 2'h0, 2'h0};
        repeat (12) @(posedge pclk);
        chk(radio_addr_bytes, 3'h2);
        chk({sram_req, radio_tx_on, radio_rx_on}, 3'h0);
        presetn <= 1'b1;
        apb(1'b0, `PRPE_OFF_CTRL, 32'h00000000);
        chk(rd, `PRPE_CTRL_RESET);
        apb(1'b1, 12'h040, 32'hFFFFFFFF);
        apb(1'b0, 12'h040, 32'h00000000);
        chk(rd, 32'h00000000);
        for (i = 0; i < 4; i = i + 1) apb(1'b1, `PRPE_OFF_RXADDR_LO + 4 * i, i[0] ? 32'h5A : 32'hA5C31E96);
        for (i = 0; i < 6; i = i + 1) begin
            slow <= i[0];
            apb(1'b1, `PRPE_OFF_CTRL, rows[i].ctrl);
            apb(1'b1, `PRPE_OFF_MODE, {29'h0, rows[i].mode});
            apb(1'b1, `PRPE_OFF_RAM, 32'h00000041);
            repeat (20) if (radio_tx_on !== 1'b1) @(posedge pclk);
            #1;
            chk(radio_tx_on, 1'b1);
            chk(sram_addr, 32'h50028010);
            chk(radio_addr_bytes, rows[i].aw);
            chk(radio_rate, rows[i].rate);
            chk(radio_whiten, rows[i].wh);
            chk(radio_crc_bytes, rows[i].crc);
            chk(radio_variant, rows[i].vr);
            chk(radio_preamble_ext, rows[i].mode[2]);
            chk(radio_len, rows[i].ctrl[23:16]);
            chk(radio_peer_addr[39:32], rows[i].aw == 3'h5 ? 8'h5A : 8'h00);
            chk(radio_peer_addr[15:0], 16'h1E96);
            poll(32'h1);
            chk(rd[0], 1'b1);
            apb(1'b1, `PRPE_OFF_STATUS, 32'h0000000F);
            apb(1'b1, `PRPE_OFF_RAM, 32'h00000000);
        end
        // Receiver with a wait field of two, expiring after three microseconds, and a silent peer.
        apb(1'b1, `PRPE_OFF_MODE, 32'h00000000);
        apb(1'b1, `PRPE_OFF_CTRL, 32'h10003001);
        apb(1'b1, `PRPE_OFF_TIMING, 32'h00000002);
        apb(1'b1, `PRPE_OFF_RAM, 32'h01000002);
        repeat (20) if (radio_rx_on !== 1'b1) @(posedge pclk);
        #1;
        chk({radio_rx_on, radio_tx_on}, 2'h2);
        poll(32'h8);
        chk(rd[3], 1'b1);
        apb(1'b1, `PRPE_OFF_STATUS, 32'h0000000F);
        apb(1'b1, `PRPE_OFF_RAM, 32'h00000000);
        // Timeout disabled: nothing may expire; then the peer sends and the packet is stored.
        apb(1'b1, `PRPE_OFF_TIMING, 32'h80000002);
        apb(1'b1, `PRPE_OFF_RAM, 32'h01000002);
        repeat (160) @(posedge pclk);
        apb(1'b0, `PRPE_OFF_STATUS, 32'h00000000);
        chk(rd[3], 1'b0);
        answer <= 1'b1;
        poll(32'h2);
        repeat (4) @(posedge pclk);
        chk({rd[1], wr_seen}, {1'b1, 32'h50028100});
        apb(1'b1, `PRPE_OFF_STATUS, 32'h0000000F);
        apb(1'b1, `PRPE_OFF_RAM, 32'h00000000);
        // Transmitter in plain reply mode: turnaround of two microseconds plus the switch time.
        apb(1'b1, `PRPE_OFF_CTRL, 32'h00103400);
        apb(1'b1, `PRPE_OFF_MODE, 32'h00000001);
        apb(1'b1, `PRPE_OFF_TIMING, 32'h00020002);
        apb(1'b1, `PRPE_OFF_RAM, 32'h01000043);
        repeat (100) if (radio_pkt_done !== 1'b1) @(posedge pclk);
        n = 0;
        while (radio_rx_on !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n = n + 1;
        end
        chk(n >= 161 && n <= 210, 1'b1);
        poll(32'h6);
        repeat (4) @(posedge pclk);
        chk({|rd[2:1], wr_seen}, {1'b1, 32'h50028100});
        apb(1'b1, `PRPE_OFF_STATUS, 32'h0000000F);
        apb(1'b1, `PRPE_OFF_RAM, 32'h00000000);
        close_out;
    end
endmodule // tb
bind prpe_engine prpe_chk prpe_chk_i (.*);
